// ===== core/scmc_defs.svh
// Purpose: Named offsets, field positions, reset values and counts for the clock/mode control.
// Assumes: Included by bare name from the package and the design modules.
// Notes:   Definitions only.
`ifndef SCMC_DEFS_SVH
`define SCMC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SCMC_ADDR_W            12
`define SCMC_OFS_SYS_CLK_SEL   12'h000
`define SCMC_OFS_FAST_OSC_CTL  12'h004

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SCMC_SCC_SEL_MSB       7
`define SCMC_SCC_SEL_LSB       5
`define SCMC_SCC_FHK_BIT       1
`define SCMC_SCC_FSK_BIT       0
`define SCMC_FOC_STAB_BIT      1
`define SCMC_FOC_EN_BIT        0

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define SCMC_SEL_RST           3'h1
`define SCMC_SEL_SUB           3'h7
`define SCMC_FHK_RST           1'h0
`define SCMC_FSK_RST           1'h0
`define SCMC_FEN_RST           1'h1
`define SCMC_FSTAB_RST         1'h0
`define SCMC_DIV_STAGES        7
`define SCMC_DIV_CNT_W         6

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SCMC_STAB_CNT_W        12
`define SCMC_FAST_STABLE_TICKS 12'h100

`endif

// ===== core/scmc_pkg.sv
// Purpose: Types shared by the clock/mode control modules.
// Assumes: scmc_defs.svh provides the widths.
// Notes:   Operating modes are one-hot.
`include "scmc_defs.svh"

package scmc_pkg;

    // ------------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------------
    typedef enum logic [5:0] {
        SCMC_FAST  = 6'h01,
        SCMC_SLOW  = 6'h02,
        SCMC_SLEEP = 6'h04,
        SCMC_IDLE0 = 6'h08,
        SCMC_IDLE1 = 6'h10,
        SCMC_IDLE2 = 6'h20
    } scmc_mode_t;

    // ------------------------------------------------------------------------
    // State records
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]                  sel;
        logic                        fhk;
        logic                        fsk;
        logic                        fen;
        logic                        fstab;
        logic [`SCMC_STAB_CNT_W-1:0] stab_cnt;
        logic                        half;
        logic [2:0]                  active_sel;
        scmc_mode_t                  mode;
        logic [31:0]                 prdata;
    } scmc_state_t;

    typedef struct packed {
        logic [`SCMC_DIV_CNT_W-1:0] cnt;
    } scmc_div_state_t;

endpackage

// ===== core/scmc_div_if.sv
// Purpose: Carries the fast clock enable into the divider and its divided pulses back.
// Assumes: One clock domain, pclk.
// Notes:   div_en[k] pulses once every 2**k fast clock enables.
`timescale 1ns/1ns
`include "scmc_defs.svh"

interface scmc_div_if;
    logic                        fast_en;
    logic [`SCMC_DIV_STAGES-1:0] div_en;

    modport ctl (output fast_en, input  div_en);
    modport div (input  fast_en, output div_en);
endinterface

// ===== core/scmc_divider.sv
// Purpose: Divides the fast clock enable by 1, 2, 4 ... 64.
// Assumes: fast_en is a one-cycle enable in the pclk domain.
// Notes:   The counter runs freely, so every divided pulse is a whole enable.
`timescale 1ns/1ns
`include "scmc_defs.svh"

module scmc_divider
    import scmc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    scmc_div_if.div   dif
);

    scmc_div_state_t st_r;
    scmc_div_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (dif.fast_en) begin
            st_nxt.cnt = st_r.cnt + `SCMC_DIV_CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Divided pulses
    // ------------------------------------------------------------------------
    // Each stage fires only at the end of its own period, so a source change
    // made on that pulse never shortens a core clock period.
    genvar k;
    generate
        for (k = 0; k < `SCMC_DIV_STAGES; k = k + 1) begin : g_stage
            if (k == 0) begin : g_first
                assign dif.div_en[k] = dif.fast_en;
            end else begin : g_rest
                assign dif.div_en[k] = dif.fast_en && (&st_r.cnt[k-1:0]);
            end
        end
    endgenerate

endmodule

// ===== core/scmc_top.sv
// Purpose: System clock selection and operating mode control with an APB register port.
// Assumes: Oscillator ticks, ready levels, halt and wake arrive synchronous to pclk.
// Notes:   All clocks leave as one-cycle enables of pclk.
//          A consumer gates its own logic with them; none of them is a clock.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "scmc_defs.svh"

module scmc_top
    import scmc_pkg::*;
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`SCMC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    output      logic [31:0]             prdata,
    output      logic                    pready,
    output      logic                    pslverr,
    input  wire logic                    fast_osc_tick,
    input  wire logic                    slow_osc_tick,
    input  wire logic                    slow_osc_ready,
    input  wire logic                    halt_req,
    input  wire logic                    wake_req,
    output      logic                    fast_osc_run,
    output      logic                    slow_osc_run,
    output      logic                    pwm_clk_en,
    output      logic                    fast_clk_en,
    output      logic                    sub_clk_en,
    output      logic                    slow_osc_clk_en,
    output      logic                    sys_clk_en,
    output      logic                    cpu_clk_en,
    output      logic [5:0]              op_mode
);

    scmc_state_t st_r;
    scmc_state_t st_nxt;
    scmc_div_if  dif ();

    scmc_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .dif     (dif)
    );

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    logic hit_scc;
    logic hit_foc;
    logic setup_ph;
    logic wr_acc;
    logic rd_setup;
    logic wr_scc;
    logic wr_foc;
    logic [31:0] rd_word;

    assign hit_scc  = (paddr == `SCMC_OFS_SYS_CLK_SEL);
    assign hit_foc  = (paddr == `SCMC_OFS_FAST_OSC_CTL);
    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = setup_ph && !pwrite;
    assign wr_scc   = wr_acc && hit_scc;
    assign wr_foc   = wr_acc && hit_foc;

    // The slave never waits; read data was captured in the setup cycle.
    // The capture costs a 32-bit register but keeps the read multiplexer
    // off the path from paddr to the prdata pins.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(hit_scc || hit_foc);

    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_scc) begin
            rd_word[`SCMC_SCC_SEL_MSB:`SCMC_SCC_SEL_LSB] = st_r.sel;
            rd_word[`SCMC_SCC_FHK_BIT]                   = st_r.fhk;
            rd_word[`SCMC_SCC_FSK_BIT]                   = st_r.fsk;
        end else if (hit_foc) begin
            rd_word[`SCMC_FOC_STAB_BIT] = st_r.fstab;
            rd_word[`SCMC_FOC_EN_BIT]   = st_r.fen;
        end
        // All other bits stay zero.
    end

    // ------------------------------------------------------------------------
    // Mode dependent clock gating
    // ------------------------------------------------------------------------
    logic sel_is_sub;
    logic fast_on;
    logic sub_on;
    logic sys_on;
    logic run_mode;
    logic fast_gate;
    logic src_pulse;
    logic cur_alive;
    logic tgt_ready;
    logic fen_rise;

    assign sel_is_sub = (st_r.active_sel == `SCMC_SEL_SUB);

    always_comb begin
        fast_on  = 1'b0;
        sub_on   = 1'b0;
        sys_on   = 1'b0;
        run_mode = 1'b0;
        case (st_r.mode)
            SCMC_FAST: begin
                fast_on  = 1'b1;
                sub_on   = 1'b1;
                sys_on   = 1'b1;
                run_mode = 1'b1;
            end
            SCMC_SLOW: begin
                fast_on  = st_r.fen;
                sub_on   = 1'b1;
                sys_on   = 1'b1;
                run_mode = 1'b1;
            end
            SCMC_IDLE0: begin
                fast_on  = 1'b0;
                sub_on   = 1'b1;
                sys_on   = sel_is_sub;
                run_mode = 1'b0;
            end
            SCMC_IDLE1: begin
                fast_on  = 1'b1;
                sub_on   = 1'b1;
                sys_on   = 1'b1;
                run_mode = 1'b0;
            end
            SCMC_IDLE2: begin
                fast_on  = 1'b1;
                sub_on   = 1'b0;
                sys_on   = !sel_is_sub;
                run_mode = 1'b0;
            end
            SCMC_SLEEP: begin
                // Only the watchdog's slow oscillator clock survives.
                fast_on  = 1'b0;
                sub_on   = 1'b0;
                sys_on   = 1'b0;
                run_mode = 1'b0;
            end
            default: begin
                // An illegal mode keeps the fast oscillator alive so that
                // the sequencer recovers to a run mode on the next edge.
                fast_on  = 1'b1;
                sub_on   = 1'b0;
                sys_on   = 1'b0;
                run_mode = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Clock enable outputs
    // ------------------------------------------------------------------------
    // The fast oscillator is not handed to the core until it is stable, so
    // a restart never feeds an unsettled clock downstream.
    assign fast_osc_run = fast_on;
    assign fast_gate    = fast_on && st_r.fstab;
    assign pwm_clk_en   = fast_osc_tick && fast_gate;
    assign fast_clk_en  = fast_osc_tick && st_r.half && fast_gate;
    assign dif.fast_en  = fast_clk_en;

    // The watchdog runs in every mode, so its oscillator is never stopped.
    assign slow_osc_run    = 1'b1;
    assign slow_osc_clk_en = slow_osc_tick;
    assign sub_clk_en      = slow_osc_tick && sub_on;

    // Current core clock source pulse.
    assign src_pulse  = sel_is_sub ? slow_osc_tick : dif.div_en[st_r.active_sel];
    assign sys_clk_en = src_pulse && sys_on;
    assign cpu_clk_en = sys_clk_en && run_mode;
    assign op_mode    = st_r.mode;
    assign prdata     = st_r.prdata;

    // A source that has stopped has no boundary to wait for; leaving it
    // cannot cut a period short.
    assign cur_alive = sel_is_sub ? 1'b1 : fast_gate;
    assign tgt_ready = (st_r.sel == `SCMC_SEL_SUB) ? slow_osc_ready : st_r.fstab;

    logic stab_last;

    assign fen_rise  = wr_foc && pwdata[`SCMC_FOC_EN_BIT] && !st_r.fen;
    assign stab_last = (st_r.stab_cnt == `SCMC_FAST_STABLE_TICKS - `SCMC_STAB_CNT_W'(1));

    // ------------------------------------------------------------------------
    // Source hand-over and halt targets
    // ------------------------------------------------------------------------
    logic       switch_now;
    logic [2:0] next_src;
    scmc_mode_t halt_mode;
    scmc_mode_t resume_mode;

    // Hand over to the requested source at the end of a whole period of the
    // old one, or at once if the old one has stopped, and once the new one is ready.
    assign switch_now  = (st_r.active_sel != st_r.sel) && tgt_ready && (src_pulse || !cur_alive);
    assign next_src    = switch_now ? st_r.sel : st_r.active_sel;
    assign resume_mode = (next_src == `SCMC_SEL_SUB) ? SCMC_SLOW : SCMC_FAST;

    // The keep bits are taken as they stand at the halt edge; a write that
    // lands in that same cycle is seen only by the next halt.
    always_comb begin
        case ({st_r.fhk, st_r.fsk})
            2'h0: begin
                halt_mode = SCMC_SLEEP;
            end
            2'h1: begin
                halt_mode = SCMC_IDLE0;
            end
            2'h3: begin
                halt_mode = SCMC_IDLE1;
            end
            2'h2: begin
                halt_mode = SCMC_IDLE2;
            end
            default: begin
                halt_mode = SCMC_SLEEP;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // --------------------------------------------------------------------
        // Register port
        // --------------------------------------------------------------------
        if (rd_setup) begin
            st_nxt.prdata = rd_word;
        end

        if (wr_scc) begin
            st_nxt.sel = pwdata[`SCMC_SCC_SEL_MSB:`SCMC_SCC_SEL_LSB];
            st_nxt.fhk = pwdata[`SCMC_SCC_FHK_BIT];
            st_nxt.fsk = pwdata[`SCMC_SCC_FSK_BIT];
        end
        if (wr_foc) begin
            st_nxt.fen = pwdata[`SCMC_FOC_EN_BIT];
        end

        // --------------------------------------------------------------------
        // Fast oscillator phase and stability
        // --------------------------------------------------------------------
        // Fast clock at half the oscillator tick rate.
        if (!fast_on) begin
            st_nxt.half = 1'b0;
        end else if (fast_osc_tick) begin
            st_nxt.half = !st_r.half;
        end

        // Stabilisation count restarts whenever the oscillator is stopped
        // or software enables it afresh.
        if (!fast_on || fen_rise) begin
            st_nxt.fstab    = 1'b0;
            st_nxt.stab_cnt = '0;
        end else if (!st_r.fstab && fast_osc_tick) begin
            if (stab_last) begin
                st_nxt.fstab = 1'b1;
            end else begin
                st_nxt.stab_cnt = st_r.stab_cnt + `SCMC_STAB_CNT_W'(1);
            end
        end

        // --------------------------------------------------------------------
        // Core clock source
        // --------------------------------------------------------------------
        st_nxt.active_sel = next_src;

        // --------------------------------------------------------------------
        // Operating mode
        // --------------------------------------------------------------------
        case (st_r.mode)
            SCMC_FAST,
            SCMC_SLOW: begin
                if (halt_req) begin
                    st_nxt.mode = halt_mode;
                end else begin
                    st_nxt.mode = resume_mode;
                end
            end
            SCMC_SLEEP,
            SCMC_IDLE0,
            SCMC_IDLE1,
            SCMC_IDLE2: begin
                // A halted mode ignores a further halt until it is woken.
                if (wake_req) begin
                    st_nxt.mode = resume_mode;
                end
            end
            default: begin
                st_nxt.mode = SCMC_FAST;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    // Reset leaves the fast oscillator running but unstable, so no fast
    // clock reaches the core until the first stabilisation count ends.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.sel        <= `SCMC_SEL_RST;
            st_r.fhk        <= `SCMC_FHK_RST;
            st_r.fsk        <= `SCMC_FSK_RST;
            st_r.fen        <= `SCMC_FEN_RST;
            st_r.fstab      <= `SCMC_FSTAB_RST;
            st_r.stab_cnt   <= '0;
            st_r.half       <= 1'b0;
            st_r.active_sel <= `SCMC_SEL_RST;
            st_r.mode       <= SCMC_FAST;
            st_r.prdata     <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

// ===== tb/scmc_props.sv
// Purpose: Port-level assertions for the clock and operating-mode control.
// Assumes: Oscillator ticks and halt requests are synchronous to pclk.
// Notes:   Bound to scmc_top after the module; sees only its ports.
`timescale 1ns/1ns

module scmc_props
    import scmc_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       fast_osc_tick,
    input wire logic       slow_osc_tick,
    input wire logic       halt_req,
    input wire logic       fast_osc_run,
    input wire logic       pwm_clk_en,
    input wire logic       fast_clk_en,
    input wire logic       sub_clk_en,
    input wire logic       slow_osc_clk_en,
    input wire logic       sys_clk_en,
    input wire logic       cpu_clk_en,
    input wire logic [5:0] op_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_wdog; slow_osc_clk_en == slow_osc_tick; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog clock lost");
    property p_pwm; pwm_clk_en |-> fast_osc_tick && fast_osc_run; endproperty
    a_pwm: assert property (p_pwm) else $error("pwm pulse without tick");
    property p_half; fast_clk_en |=> !fast_clk_en; endproperty
    a_half: assert property (p_half) else $error("fast clock not halved");
    property p_sleep; op_mode == SCMC_SLEEP |-> !(fast_clk_en || sub_clk_en || sys_clk_en); endproperty
    a_sleep: assert property (p_sleep) else $error("clock running in sleep");
    property p_idle0; op_mode == SCMC_IDLE0 |-> !fast_clk_en && sub_clk_en == slow_osc_tick; endproperty
    a_idle0: assert property (p_idle0) else $error("idle0 clocks wrong");
    property p_idle1; op_mode == SCMC_IDLE1 |-> sub_clk_en == slow_osc_tick && !cpu_clk_en; endproperty
    a_idle1: assert property (p_idle1) else $error("idle1 clocks wrong");
    property p_idle2; op_mode == SCMC_IDLE2 |-> !sub_clk_en && !cpu_clk_en; endproperty
    a_idle2: assert property (p_idle2) else $error("idle2 clocks wrong");
    property p_cpu; cpu_clk_en |-> sys_clk_en && op_mode inside {SCMC_FAST, SCMC_SLOW}; endproperty
    a_cpu: assert property (p_cpu) else $error("core clock while halted");
    property p_halt; halt_req && op_mode inside {SCMC_FAST, SCMC_SLOW} |=> op_mode > 6'h02 && $onehot(op_mode); endproperty
    a_halt: assert property (p_halt) else $error("halt not taken");
    property p_fsrc; op_mode == SCMC_FAST && sys_clk_en |-> fast_clk_en; endproperty
    a_fsrc: assert property (p_fsrc) else $error("fast mode core clock not from fast clock");
    property p_ssrc; op_mode == SCMC_SLOW && sys_clk_en |-> slow_osc_tick; endproperty
    a_ssrc: assert property (p_ssrc) else $error("slow mode core clock not from sub clock");
    property p_glitch; sys_clk_en |-> fast_clk_en || slow_osc_tick; endproperty
    a_glitch: assert property (p_glitch) else $error("core clock pulse without source");
endmodule

bind scmc_top scmc_props scmc_props_inst (.pclk, .presetn, .fast_osc_tick, .slow_osc_tick,
    .halt_req, .fast_osc_run, .pwm_clk_en, .fast_clk_en, .sub_clk_en, .slow_osc_clk_en,
    .sys_clk_en, .cpu_clk_en, .op_mode);

// ===== tb/system_clock_mode_control_tb_top.sv
// Purpose: Self-checking bench for the clock and operating-mode control.
// Assumes: Ticks are random pulses of pclk; seed fixed for repeatability.
// Notes:   Clock activity is judged by pulse counts over fixed windows.
`timescale 1ns/1ns
`include "scmc_defs.svh"

module system_clock_mode_control_tb_top
    import scmc_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [`SCMC_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q, d;
    logic pready, pslverr, e, tick_all = 0, fast_osc_tick = 0, slow_osc_tick = 0;
    logic slow_osc_ready = 0, halt_req = 0, wake_req = 0, fast_osc_run, slow_osc_run;
    logic pwm_clk_en, fast_clk_en, sub_clk_en, slow_osc_clk_en, sys_clk_en, cpu_clk_en;
    logic [5:0] op_mode;
    scmc_mode_t m;
    int fail_count = 0, n_tests = 0, seed = 58, cn[5];

    scmc_top scmc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fast_osc_tick, .slow_osc_tick, .slow_osc_ready,
        .halt_req, .wake_req, .fast_osc_run, .slow_osc_run, .pwm_clk_en, .fast_clk_en,
        .sub_clk_en, .slow_osc_clk_en, .sys_clk_en, .cpu_clk_en, .op_mode);

    always #25 pclk = ~pclk;

    always @(posedge pclk) begin
        fast_osc_tick <= tick_all | (($random(seed) & 3) != 0);
        slow_osc_tick <= (($random(seed) & 3) == 0);
    end

    task automatic check(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected %s: expected %0h, seen %0h", nm, x, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts are sampled at the edge, so they see the settled pre-edge values.
    task automatic count(input int n);
        cn = '{default: 0};
        repeat (n) begin
            @(posedge pclk);
            cn[0] += int'(cpu_clk_en === 1'b1);
            cn[1] += int'(sys_clk_en === 1'b1);
            cn[2] += int'(fast_clk_en === 1'b1);
            cn[3] += int'(sub_clk_en === 1'b1);
            cn[4] += int'(pwm_clk_en === 1'b1);
        end
    endtask

    function automatic logic [3:0] exp_on(input scmc_mode_t md, input logic s);
        case (md)
            SCMC_SLEEP: return 4'h0;
            SCMC_IDLE0: return {1'b0, s, 2'b01};
            SCMC_IDLE1: return 4'h7;
            SCMC_IDLE2: return {1'b0, !s, 2'b10};
            default:    return 4'hF;
        endcase
    endfunction

    function automatic scmc_mode_t exp_mode(input logic [1:0] k);
        case (k)
            2'h0:    return SCMC_SLEEP;
            2'h1:    return SCMC_IDLE0;
            2'h2:    return SCMC_IDLE2;
            default: return SCMC_IDLE1;
        endcase
    endfunction

    task automatic pulse(input logic wk);
        @(posedge pclk);
        if (wk) wake_req <= 1'b1;
        else halt_req <= 1'b1;
        @(posedge pclk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic conclude;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        $display("unexpected watchdog: expected end, seen hang");
        conclude;
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h000, 32'h0);
        check("select reset", 32'h20, q);
        apb(0, 12'h004, 32'h0);
        check("osc ctl reset", 32'h01, q);
        count(100);
        check("pwm before stable", 0, cn[4]);
        count(300);
        apb(0, 12'h004, 32'h0);
        check("stable flag", 32'h03, q);
        repeat (3) begin
            d = $random(seed) & 32'hFFFF_FF1F;
            apb(1, 12'h000, d);
            apb(0, 12'h000, 32'h0);
            check("reserved bits", d & 32'hE3, q);
        end
        apb(1, 12'h008, 32'hFFFF_FFFF);
        check("unmapped error", 1, e);
        apb(0, 12'h008, 32'h0);
        check("unmapped data", 0, q);
        tick_all <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            apb(1, 12'h000, k << 5);
            count(256);
            count(512);
            check("divided pulses", 512 >> (k + 1), cn[1]);
            check("core pulses", 512 >> (k + 1), cn[0]);
            check("pwm pulses", 512, cn[4]);
            check("fast pulses", 256, cn[2]);
        end
        tick_all <= 1'b0;
        apb(1, 12'h000, 32'hE0);
        count(64);
        check("switch before ready", SCMC_FAST, op_mode);
        slow_osc_ready <= 1'b1;
        count(300);
        check("switch after ready", SCMC_SLOW, op_mode);
        for (int k = 0; k < 8; k++) begin
            apb(1, 12'h000, (k[2] ? 32'hE0 : 32'h0) | k[1:0]);
            count(512);
            m = k[2] ? SCMC_SLOW : SCMC_FAST;
            count(64);
            check("run mode", m, op_mode);
            check("run clocks", exp_on(m, k[2]), {cn[0] > 0, cn[1] > 0, cn[2] > 0, cn[3] > 0});
            pulse(1'b0);
            check("halt mode", exp_mode(k[1:0]), op_mode);
            count(64);
            check("halt clocks", exp_on(exp_mode(k[1:0]), k[2]), {cn[0] > 0, cn[1] > 0, cn[2] > 0, cn[3] > 0});
            check("watchdog osc", 1, slow_osc_run);
            pulse(1'b1);
            check("wake mode", m, op_mode);
        end
        apb(1, 12'h004, 32'h2);
        count(8);
        check("osc stopped", 0, fast_osc_run);
        apb(0, 12'h004, 32'h0);
        check("flag read only", 0, q);
        count(64);
        check("pwm while stopped", 0, cn[4]);
        apb(1, 12'h004, 32'h1);
        apb(0, 12'h004, 32'h0);
        check("flag cleared", 32'h01, q);
        count(400);
        apb(0, 12'h004, 32'h0);
        check("flag restored", 32'h03, q);
        apb(1, 12'h000, 32'h0);
        count(64);
        check("back to fast", SCMC_FAST, op_mode);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h000, 32'h0);
        check("select after reset", 32'h20, q);
        apb(0, 12'h004, 32'h0);
        check("osc ctl after reset", 32'h01, q);
        check("mode after reset", SCMC_FAST, op_mode);
        conclude;
    end
endmodule
